//--- core/gpio_port_defs.vh
// register map, field positions and reset values for the general i/o port block
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

`define ADDR_W            4
`define ADDR_PORT_A_DATA  4'h0
`define ADDR_PORT_B_DATA  4'h1
`define ADDR_PORT_C_DATA  4'h2
`define ADDR_PORT_A_DIR   4'h4
`define ADDR_PORT_B_DIR   4'h5
`define ADDR_PORT_C_DIR   4'h6
`define ADDR_PULLUP       4'h8
`define ADDR_OPEN_DRAIN   4'h9
`define ADDR_PERIPH       4'hA

// pullup register fields
`define PU_A_LOW          0
`define PU_A_HIGH         1
`define PU_B_LOW          2
`define PU_B_HIGH         3
`define PU_C              4
`define PU_W              5
// open-drain register fields
`define OD_A_HIGH         0
`define OD_B_LOW          1
`define OD_B_HIGH         2
`define OD_C              3
`define OD_W              4
// peripheral enable register fields
`define PE_SERIAL         0
`define PE_EXT_INT        1
`define PE_W              2

`define DIR_RESET8        8'h00
`define DIR_RESET4        4'h0
`define CTRL_RESET5       5'h00
`define CTRL_RESET4       4'h0
`define CTRL_RESET2       2'h0
`define C_OD_ONLY_MASK    4'hC
`define C_SERIAL_IN_BIT   2
`define C_EXT_INT_BIT     3
`define PIN_LOW8          8'h00
`define PIN_LOW4          4'h0
`define DISPLAY_HIGH8     8'hFF
`define A_OD_NIBBLE       8'hF0

`endif

//--- core/gpio_sync_bank.v
// two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module gpio_sync_bank
#(
    parameter WIDTH = 20
)
(
    // clock
    input  wire             i_clock,
    // raw pin levels
    input  wire [WIDTH-1:0] i_async,
    // synchronised levels
    output reg  [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] stage_one;

    always @(posedge i_clock)
    begin
        stage_one <= i_async;
        o_sync    <= stage_one;
    end
endmodule

//--- core/general_io_port_control.v
// three-port general purpose i/o control with register access
//
// Function
// - direction bit one output, zero input
// - reset clears directions; port b serves display
// - output pin drives its latch value
// - output pin reads return latch value
// - input pin reads return sampled pin
// - writes to input-only bits ignored
// - write to input pin updates latch only
// - pullup on for input with control set
// - port c bits two, three open-drain only
// - serial enable makes bit two data input
// - interrupt enable feeds bit three onward
// - shared pins inputs at reset, display high
// - all direction bits readable and writable
// - first port upper nibble open-drain option
// - pullup off for driving outputs
// - port c latch kept through reset
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`include "gpio_port_defs.vh"
module general_io_port_control
#(
    parameter A_INPUT_ONLY = 8'h00,
    parameter B_INPUT_ONLY = 8'h00,
    parameter C_INPUT_ONLY = 4'h0
)
(
    // clock and reset
    input  wire                 i_clock,
    input  wire                 i_srst,
    // register port
    input  wire [`ADDR_W-1:0]   i_addr,
    input  wire [7:0]           i_wdata,
    input  wire                 i_write,
    input  wire                 i_read,
    output reg  [7:0]           o_rdata,
    // pin inputs
    input  wire [7:0]           i_port_a_pin,
    input  wire [7:0]           i_port_b_pin,
    input  wire [3:0]           i_port_c_pin,
    // pin drive
    output reg  [7:0]           o_port_a_out,
    output reg  [7:0]           o_port_a_oe,
    output reg  [7:0]           o_port_a_pullup,
    output reg  [7:0]           o_port_b_out,
    output reg  [7:0]           o_port_b_oe,
    output reg  [7:0]           o_port_b_pullup,
    output reg  [3:0]           o_port_c_out,
    output reg  [3:0]           o_port_c_oe,
    output reg  [3:0]           o_port_c_pullup,
    // display ownership of port b
    input  wire                 i_display_enable,
    input  wire [7:0]           i_display_frontplanes,
    output reg                  o_display_owns_b,
    // peripheral links
    output reg                  o_serial_data_in,
    output reg                  o_ext_interrupt_in
);
    localparam SYNC_W = 20;

    reg  [7:0] port_a_data;
    reg  [7:0] port_b_data;
    reg  [3:0] port_c_data;
    reg  [7:0] first_port_direction;
    reg  [7:0] second_port_direction;
    reg  [3:0] third_port_direction;
    reg  [`PU_W-1:0] pullup_ctrl;
    reg  [`OD_W-1:0] open_drain_ctrl;
    reg  [`PE_W-1:0] periph_ctrl;
    reg              display_mode;
    wire [SYNC_W-1:0] pin_sync;
    wire [7:0] a_sync;
    wire [7:0] b_sync;
    wire [3:0] c_sync;

    // pin input synchroniser
    gpio_sync_bank #(.WIDTH(SYNC_W)) u_sync
    (
        .i_clock (i_clock),
        .i_async ({i_port_c_pin, i_port_b_pin, i_port_a_pin}),
        .o_sync  (pin_sync)
    );

    assign a_sync = pin_sync[7:0];
    assign b_sync = pin_sync[15:8];
    assign c_sync = pin_sync[19:16];

    // read mux per bit: latch when output, pin when input
    function [7:0] read_mix;
        input [7:0] dir;
        input [7:0] latch;
        input [7:0] pin;
        input [7:0] input_only;
        begin
            read_mix = ((dir & ~input_only) & latch) | (~(dir & ~input_only) & pin);
        end
    endfunction

    // peripheral input, idle high while its enable is clear
    function periph_in;
        input enable;
        input pin;
        begin
            periph_in = enable ? pin : 1'b1;
        end
    endfunction

    // latch write, input-only bits keep their value
    function [7:0] latch_write;
        input [7:0] old_value;
        input [7:0] new_value;
        input [7:0] input_only;
        begin
            latch_write = (old_value & input_only) | (new_value & ~input_only);
        end
    endfunction

    // register writes
    always @(posedge i_clock)
    begin
        if (i_srst)
        begin
            first_port_direction  <= `DIR_RESET8;
            second_port_direction <= `DIR_RESET8;
            third_port_direction  <= `DIR_RESET4;
            pullup_ctrl           <= `CTRL_RESET5;
            open_drain_ctrl       <= `CTRL_RESET4;
            periph_ctrl           <= `CTRL_RESET2;
            display_mode          <= 1'b1;
            port_a_data           <= `DIR_RESET8;
            port_b_data           <= `DIR_RESET8;
        end
        else
        begin
            display_mode <= i_display_enable;
            if (i_write)
            begin
                case (i_addr)
                    `ADDR_PORT_A_DATA: port_a_data <= latch_write(port_a_data, i_wdata,
                                                                  A_INPUT_ONLY);
                    `ADDR_PORT_B_DATA: port_b_data <= latch_write(port_b_data, i_wdata,
                                                                  B_INPUT_ONLY);
                    `ADDR_PORT_A_DIR:  first_port_direction  <= i_wdata;
                    `ADDR_PORT_B_DIR:  second_port_direction <= i_wdata;
                    `ADDR_PORT_C_DIR:  third_port_direction  <= i_wdata[3:0];
                    `ADDR_PULLUP:      pullup_ctrl <= i_wdata[`PU_W-1:0];
                    `ADDR_OPEN_DRAIN:  open_drain_ctrl <= i_wdata[`OD_W-1:0];
                    `ADDR_PERIPH:      periph_ctrl <= i_wdata[`PE_W-1:0];
                    default:           port_b_data <= port_b_data;
                endcase
            end
        end
    end

    // port c latch survives reset
    always @(posedge i_clock)
    begin
        if (i_write && (i_addr == `ADDR_PORT_C_DATA))
            port_c_data <= (port_c_data & C_INPUT_ONLY) | (i_wdata[3:0] & ~C_INPUT_ONLY);
    end

    // effective directions, input-only bits never drive except on port b while the display owns it
    wire [7:0] a_dir_eff;
    wire [7:0] b_dir_eff;

    assign a_dir_eff = first_port_direction & ~A_INPUT_ONLY;
    assign b_dir_eff = second_port_direction & ~B_INPUT_ONLY;

    // output enable, open-drain bits drive only a low latch
    function [7:0] drive_enable;
        input [7:0] dir;
        input [7:0] od;
        input [7:0] latch;
        begin
            drive_enable = dir & ~(od & latch);
        end
    endfunction

    // pullup on for inputs and for released open-drain bits
    function [7:0] pullup_mix;
        input [7:0] pu_en;
        input [7:0] dir;
        input [7:0] od;
        input [7:0] latch;
        begin
            pullup_mix = pu_en & (~dir | (od & latch));
        end
    endfunction

    // pin drive decode
    reg [7:0] next_a_oe;
    reg [7:0] next_a_od;
    reg [7:0] next_a_pu_en;
    reg [7:0] next_a_pullup;
    reg [7:0] next_b_oe;
    reg [7:0] next_b_od;
    reg [7:0] next_b_pu_en;
    reg [7:0] next_b_pullup;
    reg [3:0] next_c_oe;
    reg [3:0] next_c_od;
    reg [3:0] next_c_dir;
    reg [3:0] next_c_pullup;
    reg [7:0] c_oe_wide;
    reg [7:0] c_pullup_wide;

    always @*
    begin
        next_a_od    = open_drain_ctrl[`OD_A_HIGH] ? `A_OD_NIBBLE : `PIN_LOW8;
        next_a_pu_en = {{4{pullup_ctrl[`PU_A_HIGH]}}, {4{pullup_ctrl[`PU_A_LOW]}}};
        next_b_od    = {{4{open_drain_ctrl[`OD_B_HIGH]}}, {4{open_drain_ctrl[`OD_B_LOW]}}};
        next_b_pu_en = {{4{pullup_ctrl[`PU_B_HIGH]}}, {4{pullup_ctrl[`PU_B_LOW]}}};
        // port c bits two and three are always open-drain
        next_c_od    = (open_drain_ctrl[`OD_C] ? 4'hF : 4'h0) | `C_OD_ONLY_MASK;
        next_c_dir   = third_port_direction & ~C_INPUT_ONLY;
        if (periph_ctrl[`PE_SERIAL])
            next_c_dir[`C_SERIAL_IN_BIT] = 1'b0;
        next_a_oe     = drive_enable(a_dir_eff, next_a_od, port_a_data);
        next_b_oe     = drive_enable(b_dir_eff, next_b_od, port_b_data);
        c_oe_wide     = drive_enable({4'h0, next_c_dir}, {4'h0, next_c_od}, {4'h0, port_c_data});
        next_c_oe     = c_oe_wide[3:0];
        next_a_pullup = pullup_mix(next_a_pu_en, a_dir_eff, next_a_od, port_a_data);
        next_b_pullup = pullup_mix(next_b_pu_en, b_dir_eff, next_b_od, port_b_data);
        c_pullup_wide = pullup_mix({4'h0, {4{pullup_ctrl[`PU_C]}}}, {4'h0, next_c_dir},
                                   {4'h0, next_c_od}, {4'h0, port_c_data});
        next_c_pullup = c_pullup_wide[3:0];
    end

    // registered pin outputs
    always @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_port_a_out     <= `PIN_LOW8;
            o_port_a_oe      <= `PIN_LOW8;
            o_port_a_pullup  <= `PIN_LOW8;
            o_port_b_out     <= `DISPLAY_HIGH8;
            o_port_b_oe      <= `DISPLAY_HIGH8;
            o_port_b_pullup  <= `PIN_LOW8;
            o_port_c_out     <= `PIN_LOW4;
            o_port_c_oe      <= `PIN_LOW4;
            o_port_c_pullup  <= `PIN_LOW4;
            o_display_owns_b <= 1'b1;
        end
        else
        begin
            o_port_a_out     <= port_a_data;
            o_port_a_oe      <= next_a_oe;
            o_port_a_pullup  <= next_a_pullup;
            o_display_owns_b <= display_mode;
            // display owns port b: drive its levels
            if (display_mode)
            begin
                o_port_b_out    <= i_display_frontplanes;
                o_port_b_oe     <= `DISPLAY_HIGH8;
                o_port_b_pullup <= `PIN_LOW8;
            end
            else
            begin
                o_port_b_out    <= port_b_data;
                o_port_b_oe     <= next_b_oe;
                o_port_b_pullup <= next_b_pullup;
            end
            o_port_c_out    <= port_c_data;
            o_port_c_oe     <= next_c_oe;
            o_port_c_pullup <= next_c_pullup;
        end
    end

    // peripheral inputs and register reads
    always @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_serial_data_in   <= 1'b1;
            o_ext_interrupt_in <= 1'b1;
            o_rdata            <= 8'h00;
        end
        else
        begin
            o_serial_data_in   <= periph_in(periph_ctrl[`PE_SERIAL], c_sync[`C_SERIAL_IN_BIT]);
            o_ext_interrupt_in <= periph_in(periph_ctrl[`PE_EXT_INT], c_sync[`C_EXT_INT_BIT]);
            o_rdata <= 8'h00;
            if (i_read)
            begin
                case (i_addr)
                    `ADDR_PORT_A_DATA: o_rdata <= read_mix(first_port_direction, port_a_data,
                                                           a_sync, A_INPUT_ONLY);
                    `ADDR_PORT_B_DATA: o_rdata <= read_mix(second_port_direction, port_b_data,
                                                           b_sync, B_INPUT_ONLY);
                    `ADDR_PORT_C_DATA: o_rdata <= read_mix({4'h0, third_port_direction},
                                                           {4'h0, port_c_data}, {4'h0, c_sync},
                                                           {4'h0, C_INPUT_ONLY});
                    `ADDR_PORT_A_DIR:  o_rdata <= first_port_direction;
                    `ADDR_PORT_B_DIR:  o_rdata <= second_port_direction;
                    `ADDR_PORT_C_DIR:  o_rdata <= {4'h0, third_port_direction};
                    `ADDR_PULLUP:      o_rdata <= {3'h0, pullup_ctrl};
                    `ADDR_OPEN_DRAIN:  o_rdata <= {4'h0, open_drain_ctrl};
                    `ADDR_PERIPH:      o_rdata <= {6'h00, periph_ctrl};
                    default:           o_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

//--- tb/gpio_port_checker.sv
// concurrent checks on the general i/o port block
`timescale 1ns/10ps
`include "gpio_port_defs.vh"
module gpio_port_checker
(
    // clock, reset, register port
    input wire               i_clock,
    input wire               i_srst,
    input wire [`ADDR_W-1:0] i_addr,
    input wire [7:0]         i_wdata,
    input wire               i_write,
    input wire               i_read,
    input wire [7:0]         o_rdata,
    // pin drive
    input wire [7:0]         o_port_a_out,
    input wire [7:0]         o_port_a_oe,
    input wire [7:0]         o_port_a_pullup,
    input wire [7:0]         o_port_b_oe,
    input wire [7:0]         o_port_b_pullup,
    input wire [3:0]         o_port_c_out,
    input wire [3:0]         o_port_c_oe,
    input wire [3:0]         o_port_c_pullup,
    // display and peripheral links
    input wire               o_display_owns_b,
    input wire               o_serial_data_in,
    input wire               o_ext_interrupt_in
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    chk_rdata_idle: assert property (!$past(i_read) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    chk_reset_state: assert property ($past(i_srst) |-> o_port_a_oe == 8'h00 && o_port_c_oe == 4'h0
        && o_port_b_oe == 8'hFF && o_display_owns_b && o_port_c_pullup == 4'h0)
        else $error("pins not in reset state");
    chk_a_oe_dir: assert property (i_write && i_addr == `ADDR_PORT_A_DIR
        |-> ##2 o_port_a_oe[3:0] == $past(i_wdata[3:0], 2))
        else $error("port a enable does not follow direction");
    chk_a_out_latch: assert property (i_write && i_addr == `ADDR_PORT_A_DATA
        |-> ##2 (o_port_a_out[3:0] & o_port_a_oe[3:0]) == ($past(i_wdata[3:0], 2) & o_port_a_oe[3:0]))
        else $error("port a drive does not follow latch");
    chk_c_od_only: assert property ((o_port_c_oe[3:2] & o_port_c_out[3:2]) == 2'b00)
        else $error("port c upper bits drive high");
    chk_pullup_drive: assert property ((o_port_a_pullup & o_port_a_oe) == 8'h00
        && (o_port_b_pullup & o_port_b_oe) == 8'h00 && (o_port_c_pullup & o_port_c_oe) == 4'h0)
        else $error("pullup on at a driven pin");
    chk_periph_off: assert property (i_write && i_addr == `ADDR_PERIPH && i_wdata[1:0] == 2'b00
        |-> ##2 o_serial_data_in && o_ext_interrupt_in)
        else $error("peripheral inputs not idle high");
    chk_dir_readback: assert property (i_write && i_addr == `ADDR_PORT_A_DIR ##1 !i_write
        ##1 i_read && i_addr == `ADDR_PORT_A_DIR |=> o_rdata == $past(i_wdata, 3))
        else $error("direction read back differs");

    cover property (i_read ##1 o_rdata != 8'h00);
    cover property ($fell(o_display_owns_b));
    cover property (o_port_c_oe[3:2] == 2'b11);
endmodule

bind general_io_port_control gpio_port_checker chk_i
(
    .i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .o_port_a_out(o_port_a_out),
    .o_port_a_oe(o_port_a_oe), .o_port_a_pullup(o_port_a_pullup), .o_port_b_oe(o_port_b_oe),
    .o_port_b_pullup(o_port_b_pullup), .o_port_c_out(o_port_c_out), .o_port_c_oe(o_port_c_oe),
    .o_port_c_pullup(o_port_c_pullup), .o_display_owns_b(o_display_owns_b),
    .o_serial_data_in(o_serial_data_in), .o_ext_interrupt_in(o_ext_interrupt_in)
);

//--- tb/general_io_port_control_tb.sv
// self-checking bench for the general i/o port block
`timescale 1ns/10ps
module general_io_port_control_tb;
    logic       i_clock = 1'b0;
    logic       i_srst = 1'b1;
    logic       i_write = 1'b0;
    logic       i_read = 1'b0;
    logic       i_display_enable = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [3:0] i_port_c_pin = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] i_port_a_pin = 8'h00;
    logic [7:0] i_port_b_pin = 8'h00;
    logic [7:0] i_display_frontplanes = 8'h00;
    wire  [7:0] o_rdata, o_port_a_out, o_port_a_oe, o_port_a_pullup;
    wire  [7:0] o_port_b_out, o_port_b_oe, o_port_b_pullup;
    wire  [3:0] o_port_c_out, o_port_c_oe, o_port_c_pullup;
    wire        o_display_owns_b, o_serial_data_in, o_ext_interrupt_in;
    int         error_cnt = 0;
    int         n_compared = 0;
    int         k;
    localparam logic [7:0] a_in_only = 8'h80;
    logic [7:0] m, d, p, r, io;

    always #50 i_clock = ~i_clock;

    general_io_port_control #(.A_INPUT_ONLY(a_in_only)) uut
    (
        .i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
        .i_read(i_read), .o_rdata(o_rdata), .i_port_a_pin(i_port_a_pin), .i_port_b_pin(i_port_b_pin),
        .i_port_c_pin(i_port_c_pin), .o_port_a_out(o_port_a_out), .o_port_a_oe(o_port_a_oe),
        .o_port_a_pullup(o_port_a_pullup), .o_port_b_out(o_port_b_out), .o_port_b_oe(o_port_b_oe),
        .o_port_b_pullup(o_port_b_pullup), .o_port_c_out(o_port_c_out), .o_port_c_oe(o_port_c_oe),
        .o_port_c_pullup(o_port_c_pullup), .i_display_enable(i_display_enable),
        .i_display_frontplanes(i_display_frontplanes), .o_display_owns_b(o_display_owns_b),
        .o_serial_data_in(o_serial_data_in), .o_ext_interrupt_in(o_ext_interrupt_in)
    );

    function automatic logic [7:0] exp_read(input logic [7:0] dir, latch, pin);
        logic [7:0] v;
        for (int i = 0; i < 8; i++)
            v[i] = dir[i] ? latch[i] : pin[i];
        return v;
    endfunction

    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task wt(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= v;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask

    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        v = o_rdata;
    endtask

    task rst;
        i_srst <= 1'b1;
        repeat (3) @(posedge i_clock);
        i_srst <= 1'b0;
        #1;
    endtask

    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #400000;
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        void'($urandom(76));
        rst();
        chk("b_out", 8'hFF, o_port_b_out);
        chk("b_oe", 8'hFF, o_port_b_oe);
        chk("a_oe", 8'h00, o_port_a_oe);
        for (k = 0; k < 16; k++)
        begin
            rd(k[3:0], r);
            chk("reset_reg", 8'h00, r);
        end
        chk("owns_b", 8'h00, {7'h00, o_display_owns_b});
        $display("reset test done");
        for (k = 0; k < 2; k++)
        begin
            m = $urandom;
            d = $urandom;
            p = $urandom;
            io = k ? 8'h00 : a_in_only;
            i_port_a_pin <= p;
            i_port_b_pin <= p;
            wr(4'h4 + k[3:0], m);
            rd(4'h4 + k[3:0], r);
            chk("dir", m, r);
            wr(k[3:0], d);
            wt(4);
            rd(k[3:0], r);
            chk("data", exp_read(m & ~io, d & ~io, p), r);
            chk("oe", m & ~io, k ? o_port_b_oe : o_port_a_oe);
            chk("out", d & m & ~io, (k ? o_port_b_out : o_port_a_out) & m);
        end
        wr(4'h9, 8'h06);
        wr(4'h8, 8'h0C);
        wt(2);
        chk("b_od_oe", m & ~d, o_port_b_oe);
        chk("b_od_pu", ~(m & ~d), o_port_b_pullup);
        $display("port test done");
        wr(4'h4, 8'h0F);
        wr(4'h8, 8'h03);
        wt(2);
        chk("a_pu", 8'hF0, o_port_a_pullup);
        wr(4'h9, 8'h01);
        wr(4'h4, 8'hFF);
        wr(4'h0, 8'hF0);
        wt(2);
        chk("a_od_oe", 8'h0F, o_port_a_oe);
        chk("a_od_pu", 8'hF0, o_port_a_pullup);
        $display("pullup test done");
        wr(4'h2, 8'h00);
        wt(2);
        chk("c_in_oe", 8'h00, {4'h0, o_port_c_oe});
        wr(4'h6, 8'hFF);
        wt(2);
        chk("c_oe", 8'h0F, {4'h0, o_port_c_oe});
        chk("c_out", 8'h00, {4'h0, o_port_c_out});
        wr(4'h2, 8'h0C);
        wr(4'h8, 8'h10);
        wt(2);
        chk("c_oe", 8'h03, {4'h0, o_port_c_oe});
        chk("c_pu", 8'h0C, {4'h0, o_port_c_pullup});
        p = $urandom;
        i_port_c_pin <= p[3:0];
        wr(4'hA, 8'h03);
        wt(4);
        chk("sdi", {7'h00, p[2]}, {7'h00, o_serial_data_in});
        chk("irq", {7'h00, p[3]}, {7'h00, o_ext_interrupt_in});
        rd(4'h2, r);
        chk("c_rd", 8'h0C, r);
        wr(4'h6, 8'h00);
        wt(4);
        rd(4'h2, r);
        chk("c_pin", {4'h0, p[3:0]}, r);
        chk("c_pu", 8'h0F, {4'h0, o_port_c_pullup});
        wr(4'hA, 8'h00);
        $display("port c test done");
        wr(4'h2, 8'h05);
        rst();
        wr(4'h6, 8'hFF);
        rd(4'h2, r);
        chk("c_keep", 8'h05, r);
        $display("keep test done");
        p = $urandom;
        i_display_frontplanes <= p;
        i_display_enable <= 1'b1;
        wt(4);
        chk("disp_out", p, o_port_b_out);
        chk("disp_oe", 8'hFF, o_port_b_oe);
        $display("display test done");
        tally_and_finish();
    end
endmodule
